// File: rtl/swec_status_ctrl.v
/*
  Status-register and write-enable command interpreter of a serial flash.
  Decodes write enable, volatile write enable, write disable, the three
  status reads and the three status writes from the serial pins, keeps the
  volatile and non-volatile status images and runs the self-timed write.
  Assumes: SCLK, CS_N and IO_IN come from the pins and are synchronised
  here; SCLK is well below a quarter of CLK; QUAD_COMMAND_MODE, RESET_REQ,
  OP_DONE and EXT_BUSY come from logic on CLK.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swec_defs.vh"

module swec_status_ctrl #(
  parameter [16:0] TW_CYC = `SWEC_TW_CYC
) (
  input wire CLK,
  input wire NRST,
  input wire SCLK,
  input wire CS_N,
  input wire [3:0] IO_IN,
  output wire [3:0] IO_OUT,
  output wire [3:0] IO_OE,
  input wire QUAD_COMMAND_MODE,
  input wire RESET_REQ,
  input wire OP_DONE,
  input wire EXT_BUSY,
  output wire WRITE_LATCH_FLAG,
  output wire BUSY,
  output wire [7:0] STATUS_REG1,
  output wire [7:0] STATUS_REG2,
  output wire [7:0] STATUS_REG3
);

  localparam [16:0] TSHSL2_CYC = `SWEC_TSHSL2_CYC;

  // ----------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  reg [1:0] sclk_s_r;
  reg [1:0] cs_s_r;
  reg [3:0] io_s1_r;
  reg [3:0] io_s2_r;
  reg sclk_d_r;
  reg cs_d_r;

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_s_r <= 2'h0;
      cs_s_r <= 2'h3;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_s_r <= {sclk_s_r[0], SCLK};
      cs_s_r <= {cs_s_r[0], CS_N};
      io_s1_r <= IO_IN;
      io_s2_r <= io_s1_r;
      sclk_d_r <= sclk_s_r[1];
      cs_d_r <= cs_s_r[1];
    end
  end

  wire sel = ~cs_s_r[1];
  wire sclk_rise = sel & sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = sel & ~sclk_s_r[1] & sclk_d_r;
  wire frame_end = cs_s_r[1] & ~cs_d_r;
  wire quad = QUAD_COMMAND_MODE;
  wire [3:0] step = quad ? 4'h4 : 4'h1;

  // ----------------------------------------------------------------------
  // command and data byte capture
  // ----------------------------------------------------------------------
  reg [7:0] in_sh_r;
  reg [2:0] bit_cnt_r;
  reg [2:0] byte_cnt_r;
  reg [7:0] cmd_r;
  reg [7:0] d1_r;
  reg [7:0] d2_r;
  reg rd_on_r;
  reg [1:0] rd_sel_r;

  // MSB arrives first, so new bits enter at the bottom
  wire [7:0] in_nxt = quad ? {in_sh_r[3:0], io_s2_r} : {in_sh_r[6:0], io_s2_r[0]};
  wire [3:0] bc_sum = {1'b0, bit_cnt_r} + step;
  wire byte_done = sclk_rise & bc_sum[3];

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      in_sh_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      cmd_r <= 8'h00;
      d1_r <= 8'h00;
      d2_r <= 8'h00;
      rd_on_r <= 1'b0;
      rd_sel_r <= 2'h0;
    end else if (!sel) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      rd_on_r <= 1'b0;
    end else if (sclk_rise) begin
      in_sh_r <= in_nxt;
      bit_cnt_r <= bc_sum[2:0];
      if (byte_done) begin
        if (byte_cnt_r != 3'h4)
          byte_cnt_r <= byte_cnt_r + 3'h1;
        if (byte_cnt_r == 3'h1)
          d1_r <= in_nxt;
        if (byte_cnt_r == 3'h2)
          d2_r <= in_nxt;
        if (byte_cnt_r == 3'h0) begin
          cmd_r <= in_nxt;
          case (in_nxt)
            `SWEC_CMD_RD_STATUS1: begin
              rd_on_r <= 1'b1;
              rd_sel_r <= 2'h0;
            end
            `SWEC_CMD_RD_STATUS2: begin
              rd_on_r <= 1'b1;
              rd_sel_r <= 2'h1;
            end
            `SWEC_CMD_RD_STATUS3: begin
              rd_on_r <= 1'b1;
              rd_sel_r <= 2'h2;
            end
            default: begin
              rd_on_r <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // status images
  // ----------------------------------------------------------------------
  reg wel_r;
  reg busy_r;
  reg varm_r;
  reg tmr_on_r;
  reg pend_nv_r;
  reg [16:0] tmr_r;
  reg [2:0] pend_en_r;
  reg [23:0] pend_d_r;
  wire [23:0] nv_img;
  wire [23:0] vol_img;
  wire tmr_end = tmr_on_r & (tmr_r == 17'h0);
  wire busy_any = busy_r | EXT_BUSY;

  // keeps read-only bits, OTP bits and, when asked, lock1 and quad enable
  function [7:0] merge;
    input integer idx;
    input [7:0] old;
    input [7:0] d;
    input vol;
    input qmode;
    reg [7:0] m;
    reg [7:0] r;
    begin
      m = (idx == 32'h0) ? `SWEC_SR1_WMASK :
          (idx == 32'h1) ? `SWEC_SR2_WMASK : `SWEC_SR3_WMASK;
      r = (old & ~m) | (d & m);
      if (idx == 32'h1) begin
        r = r | (old & `SWEC_SR2_OTP_MASK);
        if (vol)
          r = r | (old & `SWEC_SR2_LOCK1_MASK);
        if (qmode)
          r = (r & ~`SWEC_SR2_QE_MASK) | (old & `SWEC_SR2_QE_MASK);
      end
      merge = r;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : img
      localparam [7:0] NV_INIT = (g == 0) ? `SWEC_NV1_INIT :
                                 (g == 1) ? `SWEC_NV2_INIT : `SWEC_NV3_INIT;
      reg [7:0] nv_r;
      reg [7:0] vol_r;
      wire apply = tmr_end & pend_en_r[g];
      always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          nv_r <= NV_INIT;
          vol_r <= NV_INIT;
        end else if (apply & pend_nv_r) begin
          nv_r <= merge(g, nv_r, pend_d_r[8*g +: 8], 1'b0, quad);
          vol_r <= merge(g, nv_r, pend_d_r[8*g +: 8], 1'b0, quad);
        end else if (apply) begin
          vol_r <= merge(g, vol_r, pend_d_r[8*g +: 8], 1'b1, quad);
        end else if (RESET_REQ) begin
          vol_r <= nv_r;
        end
      end
      assign nv_img[8*g +: 8] = nv_r;
      assign vol_img[8*g +: 8] = vol_r;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // frame-end decode and self-timed write
  // ----------------------------------------------------------------------
  wire whole = (bit_cnt_r == 3'h0);
  wire one_byte = whole & (byte_cnt_r == 3'h1);
  wire is_wr1 = (cmd_r == `SWEC_CMD_WR_STATUS1);
  wire is_wr23 = (cmd_r == `SWEC_CMD_WR_STATUS2) | (cmd_r == `SWEC_CMD_WR_STATUS3);
  wire wr_len_ok = whole & ((byte_cnt_r == 3'h2) | (is_wr1 & (byte_cnt_r == 3'h3)));
  wire wr_cmd = frame_end & ~busy_any & (is_wr1 | is_wr23) & wr_len_ok;
  wire act = frame_end & ~busy_any;
  wire do_wren = act & one_byte & (cmd_r == `SWEC_CMD_WR_ENABLE);
  wire do_vol = act & one_byte & (cmd_r == `SWEC_CMD_VOL_ENABLE);
  wire do_wrdi = act & one_byte & (cmd_r == `SWEC_CMD_WR_DISABLE);
  wire start_vol = wr_cmd & varm_r;
  wire start_nv = wr_cmd & ~varm_r & wel_r;

  reg [2:0] en_nxt;
  reg [23:0] d_nxt;

  always @* begin
    en_nxt = 3'h0;
    d_nxt = 24'h000000;
    if (is_wr1) begin
      en_nxt = (byte_cnt_r == 3'h3) ? 3'h3 : 3'h1;
      d_nxt = {8'h00, d2_r, d1_r};
    end else if (cmd_r == `SWEC_CMD_WR_STATUS2) begin
      en_nxt = 3'h2;
      d_nxt = {8'h00, d1_r, 8'h00};
    end else begin
      en_nxt = 3'h4;
      d_nxt = {d1_r, 16'h0000};
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      busy_r <= 1'b0;
      tmr_on_r <= 1'b0;
      tmr_r <= 17'h0;
      pend_nv_r <= 1'b0;
      pend_en_r <= 3'h0;
      pend_d_r <= 24'h000000;
    end else if (start_nv | start_vol) begin
      tmr_on_r <= 1'b1;
      busy_r <= start_nv;
      tmr_r <= start_nv ? TW_CYC - 17'h1 : TSHSL2_CYC - 17'h1;
      pend_nv_r <= start_nv;
      pend_en_r <= en_nxt;
      pend_d_r <= d_nxt;
    end else if (tmr_end) begin
      tmr_on_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (tmr_on_r) begin
      tmr_r <= tmr_r - 17'h1;
    end
  end

  // clears come first so a set in the same cycle wins
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wel_r <= 1'b0;
      varm_r <= 1'b0;
    end else begin
      if (OP_DONE | RESET_REQ | (tmr_end & pend_nv_r) | do_wrdi)
        wel_r <= 1'b0;
      if (do_wren)
        wel_r <= 1'b1;
      if (RESET_REQ | do_wren | do_wrdi | wr_cmd)
        varm_r <= 1'b0;
      if (do_vol)
        varm_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // status read-out
  // ----------------------------------------------------------------------
  wire [7:0] sr1 = {vol_img[7:2], wel_r, busy_any};
  wire [7:0] sr2 = vol_img[15:8];
  wire [7:0] sr3 = vol_img[23:16];
  wire [7:0] cur = (rd_sel_r == 2'h0) ? sr1 : (rd_sel_r == 2'h1) ? sr2 : sr3;

  reg [7:0] out_sh_r;
  reg [2:0] out_cnt_r;
  reg [3:0] io_out_r;
  reg [7:0] cur_w;

  always @* begin
    cur_w = (out_cnt_r == 3'h0) ? cur : out_sh_r;
  end

  // the register is sampled afresh at every byte so busy polling tracks
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out_sh_r <= 8'h00;
      out_cnt_r <= 3'h0;
      io_out_r <= 4'h0;
    end else if (!rd_on_r) begin
      out_cnt_r <= 3'h0;
    end else if (sclk_fall) begin
      out_cnt_r <= out_cnt_r + step[2:0];
      if (quad) begin
        io_out_r <= cur_w[7:4];
        out_sh_r <= {cur_w[3:0], 4'h0};
      end else begin
        io_out_r <= {2'h0, cur_w[7], 1'b0};
        out_sh_r <= {cur_w[6:0], 1'b0};
      end
    end
  end

  assign IO_OUT = io_out_r;
  assign IO_OE = (rd_on_r & sel) ? (quad ? 4'hf : 4'h2) : 4'h0;
  assign WRITE_LATCH_FLAG = wel_r;
  assign BUSY = busy_r;
  assign STATUS_REG1 = sr1;
  assign STATUS_REG2 = sr2;
  assign STATUS_REG3 = sr3;

endmodule

`default_nettype wire

// File: rtl/swec_defs.vh
/*
  Constants of the status / write-enable command block of a serial flash:
  command codes, writable-field masks, non-volatile reset images and the
  self-timed durations with their clock-cycle counts.
  Assumes a 125 MHz system clock; the file holds definitions only.
*/
`ifndef SWEC_DEFS_VH
`define SWEC_DEFS_VH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define SWEC_CMD_WR_ENABLE 8'h06
`define SWEC_CMD_VOL_ENABLE 8'h50
`define SWEC_CMD_WR_DISABLE 8'h04
`define SWEC_CMD_RD_STATUS1 8'h05
`define SWEC_CMD_RD_STATUS2 8'h35
`define SWEC_CMD_RD_STATUS3 8'h15
`define SWEC_CMD_WR_STATUS1 8'h01
`define SWEC_CMD_WR_STATUS2 8'h31
`define SWEC_CMD_WR_STATUS3 8'h11

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
// register 1: protect_lock_bit0, sector, top_bottom, block_protect_field
`define SWEC_SR1_WMASK 8'hfc
`define SWEC_SR1_LATCH_BIT 1
`define SWEC_SR1_BUSY_BIT 0
// register 2: complement, one_time_lock_bits, quad_enable, protect_lock_bit1
`define SWEC_SR2_WMASK 8'h7f
`define SWEC_SR2_OTP_MASK 8'h3c
`define SWEC_SR2_LOCK1_MASK 8'h01
`define SWEC_SR2_QE_MASK 8'h02
// register 3: hold/reset select, drive_strength_hi/lo, protect_scheme_select
`define SWEC_SR3_WMASK 8'he4

// ----------------------------------------------------------------------
// reset values of the non-volatile images
// ----------------------------------------------------------------------
`define SWEC_NV1_INIT 8'h00
`define SWEC_NV2_INIT 8'h00
`define SWEC_NV3_INIT 8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SWEC_CLK_NS 8
`define SWEC_TW_NS 1000000
`define SWEC_TSHSL2_NS 50
// the durations above in clock cycles, sized to the 17-bit write timer;
// the short window is rounded down so the update lands inside it
`define SWEC_TW_CYC 17'h1e848
`define SWEC_TSHSL2_CYC 17'h6

`endif

// File: testbench/swec_status_ctrl_assertions.sv
/*
  Checker of the status and write-latch block, bound to its top module.
  Assumes one clock domain and TW_CYC handed on by the bind.
*/
`timescale 1ns/100ps
`default_nettype none
module swec_status_ctrl_assertions #(
  parameter [16:0] TW_CYC = 17'h14
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CS_N,
  input wire logic QUAD_COMMAND_MODE,
  input wire logic RESET_REQ,
  input wire logic OP_DONE,
  input wire logic [3:0] IO_OE,
  input wire logic WRITE_LATCH_FLAG,
  input wire logic BUSY,
  input wire logic [7:0] STATUS_REG1,
  input wire logic [7:0] STATUS_REG2,
  input wire logic [7:0] STATUS_REG3
);
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  logic [16:0] busy_cnt_r;
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) busy_cnt_r <= 17'h0;
    else busy_cnt_r <= BUSY ? busy_cnt_r + 17'h1 : 17'h0;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_cs_idle; CS_N [*4]; endsequence
  sequence s_busy_start; !BUSY ##1 BUSY; endsequence
  AST_BUSY_LEN: assert property ($fell(BUSY) |-> busy_cnt_r == TW_CYC)
    else $error("busy length wrong");
  AST_BUSY_NEEDS_LATCH: assert property (s_busy_start |-> WRITE_LATCH_FLAG)
    else $error("busy without latch");
  AST_LATCH_HELD: assert property (BUSY |-> WRITE_LATCH_FLAG)
    else $error("latch lost while busy");
  AST_LATCH_END: assert property ($fell(BUSY) |-> !WRITE_LATCH_FLAG)
    else $error("latch kept after write");
  AST_LATCH_DONE: assert property ((OP_DONE || RESET_REQ) && CS_N |=> !WRITE_LATCH_FLAG)
    else $error("latch kept after done");
  AST_SR1_LATCH: assert property (STATUS_REG1[1] == WRITE_LATCH_FLAG)
    else $error("latch bit mismatch");
  AST_RO_BITS: assert property (!STATUS_REG2[7] && (STATUS_REG3 & 8'h1b) == 8'h0)
    else $error("read-only bit set");
  AST_OTP: assert property (
    !RESET_REQ |=> ($past(STATUS_REG2) & ~STATUS_REG2 & 8'h3c) == 8'h0)
    else $error("lock bit cleared");
  AST_OE_WIDTH: assert property (
    IO_OE != 4'h0 |-> IO_OE == (QUAD_COMMAND_MODE ? 4'hf : 4'h2))
    else $error("bad output enable");
  AST_OE_END: assert property (s_cs_idle |-> IO_OE == 4'h0)
    else $error("driving after select");
endmodule
bind swec_status_ctrl swec_status_ctrl_assertions #(.TW_CYC(TW_CYC)) chk_u (
  .CLK(CLK), .NRST(NRST), .CS_N(CS_N), .QUAD_COMMAND_MODE(QUAD_COMMAND_MODE),
  .RESET_REQ(RESET_REQ), .OP_DONE(OP_DONE), .IO_OE(IO_OE),
  .WRITE_LATCH_FLAG(WRITE_LATCH_FLAG), .BUSY(BUSY), .STATUS_REG1(STATUS_REG1),
  .STATUS_REG2(STATUS_REG2), .STATUS_REG3(STATUS_REG3));
`default_nettype wire

// File: testbench/swec_host_model.sv
/*
  Host flash controller: drives select, serial clock and data lines.
  Assumes io_w is the resolved pin level and, while the device drives it, changes on rising clk.
*/
`timescale 1ns/100ps
`default_nettype none
module swec_host_model (
  input wire logic clk,
  input wire logic quad,
  input wire logic [3:0] io_w,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_drv
);
  logic [15:0] rd;
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    io_drv = 4'h0;
    rd = 16'h0;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ------------------------------------------------------------------
  // one frame: nb bits out, left aligned in d, then nr bits read
  // ------------------------------------------------------------------
  task automatic frame(input logic [23:0] d, input int nb, input int nr);
    int i;
    int w;
    w = quad ? 4 : 1;
    cs_n = 1'h0;
    for (i = 0; i < nb + nr; i += w) begin
      if (i < nb) io_drv = quad ? d[23 - i -: 4] : {~io_drv[3:1], d[23 - i]};
      else io_drv = ~io_drv;
      step(4);
      sclk = 1'h1;
      step(2);
      if (i >= nb) rd = quad ? {rd[11:0], io_w} : {rd[14:0], io_w[1]};
      step(2);
      sclk = 1'h0;
    end
    step(4);
    cs_n = 1'h1;
    io_drv = ~io_drv;
    step(16);
  endtask
endmodule
`default_nettype wire

// File: testbench/test_swec_status_ctrl.sv
/*
  Self-checking bench of the status and write-latch block.
  Assumes the host model and the bound checker beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module test_swec_status_ctrl;
  logic clk, nrst, quad, rst_req, op_done, ext_busy, sclk, cs_n, busy, wlf;
  logic [3:0] io_w, io_drv, io_out, io_oe;
  logic [7:0] sr1, sr2, sr3;
  int err_total, samples_checked;
  assign io_w = (io_oe & io_out) | (~io_oe & io_drv);
  swec_status_ctrl #(.TW_CYC(17'h190)) dut_u (.CLK(clk), .NRST(nrst), .SCLK(sclk),
    .CS_N(cs_n), .IO_IN(io_w), .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_COMMAND_MODE(quad),
    .RESET_REQ(rst_req), .OP_DONE(op_done), .EXT_BUSY(ext_busy), .WRITE_LATCH_FLAG(wlf),
    .BUSY(busy), .STATUS_REG1(sr1), .STATUS_REG2(sr2), .STATUS_REG3(sr3));
  swec_host_model host_u (.clk(clk), .quad(quad), .io_w(io_w), .cs_n(cs_n), .sclk(sclk),
    .io_drv(io_drv));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 2000 && busy !== 1'h0; i++) cyc(1);
    if (i == 2000) begin
      err_total++;
      $display("[ERR] %0t busy never ends", $time);
      stop_test;
    end
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_latch;
    host_u.frame(24'h060000, 7, 0);
    chk(wlf, 1'h0);
    host_u.frame(24'h060000, 8, 0);
    chk(wlf, 1'h1);
    host_u.frame(24'h040000, 8, 0);
    chk(wlf, 1'h0);
    host_u.frame(24'h060000, 8, 0);
    op_done = 1'h1;
    cyc(1);
    op_done = 1'h0;
    cyc(1);
    chk(wlf, 1'h0);
    host_u.frame(24'h500000, 8, 0);
    chk(wlf, 1'h0);
    host_u.frame(24'h040000, 8, 0);
  endtask
  task automatic t_nv;
    host_u.frame(24'h31ff00, 16, 0);
    chk({busy, sr2}, 9'h0);
    host_u.frame(24'h060000, 8, 0);
    host_u.frame(24'h01ff00, 16, 0);
    chk(busy, 1'h1);
    host_u.frame(24'h050000, 8, 8);
    chk(host_u.rd[7:0], 8'h03);
    wait_idle;
    chk({wlf, sr1, sr2}, 17'hfc00);
  endtask
  task automatic t_two;
    host_u.frame(24'h060000, 8, 0);
    host_u.frame(24'h01a442, 24, 0);
    wait_idle;
    chk({sr1, sr2}, 16'ha442);
    host_u.frame(24'h060000, 8, 0);
    host_u.frame(24'h11ff00, 16, 0);
    wait_idle;
    chk(sr3, 8'he4);
  endtask
  task automatic t_read;
    logic [7:0] code [3] = '{8'h05, 8'h35, 8'h15};
    logic [7:0] exp [3] = '{8'ha4, 8'h42, 8'he4};
    for (int k = 0; k < 3; k++) begin
      host_u.frame({code[k], 16'h0}, 8, 16);
      chk(host_u.rd, {exp[k], exp[k]});
    end
  endtask
  task automatic t_vol;
    host_u.frame(24'h500000, 8, 0);
    host_u.frame(24'h313d00, 16, 0);
    chk({wlf, busy, sr2}, 10'h3d);
    host_u.frame(24'h500000, 8, 0);
    host_u.frame(24'h310000, 16, 0);
    chk(sr2, 8'h3d);
    host_u.frame(24'h060000, 8, 0);
    chk(wlf, 1'h1);
    rst_req = 1'h1;
    cyc(1);
    rst_req = 1'h0;
    cyc(1);
    chk({wlf, sr2}, 9'h42);
  endtask
  task automatic t_quad;
    quad = 1'h1;
    host_u.frame(24'h060000, 8, 0);
    host_u.frame(24'h310000, 16, 0);
    wait_idle;
    chk(sr2, 8'h02);
    host_u.frame(24'h350000, 8, 16);
    chk(host_u.rd, 16'h0202);
    quad = 1'h0;
  endtask
  task automatic t_ext;
    ext_busy = 1'h1;
    cyc(2);
    chk(sr1[0], 1'h1);
    host_u.frame(24'h060000, 8, 0);
    chk(wlf, 1'h0);
    ext_busy = 1'h0;
  endtask
  initial begin
    nrst = 1'h0;
    quad = 1'h0;
    rst_req = 1'h0;
    op_done = 1'h0;
    ext_busy = 1'h0;
    err_total = 0;
    samples_checked = 0;
    cyc(10);
    nrst = 1'h1;
    cyc(2);
    chk({wlf, busy, sr1, sr2, sr3}, 32'h0);
    t_latch;
    t_nv;
    t_two;
    t_read;
    t_vol;
    t_quad;
    t_ext;
    stop_test;
  end
endmodule
`default_nettype wire
